// ===== hdl/tmc_pkg.sv
// Package: message codes, layout and return codes for the task management handler
package tmc_pkg;
  localparam logic [7:0] MSG_CODE = 8'h83;
  localparam logic [7:0] FN_CLEAR_TASK_SET = 8'h32;
  localparam logic [7:0] FN_TARGET_RESET = 8'h33;
  localparam logic [7:0] FN_CLEAR_ALLEGIANCE = 8'h34;
  localparam logic [7:0] FN_RESPONSE = 8'h03;
  localparam logic [7:0] RC_SUCCESS = 8'h00;
  localparam logic [7:0] RC_NO_ALLEGIANCE = 8'h20;
  localparam logic [7:0] RC_INVALID_FIELD = 8'hFF;
  localparam int MSG_BYTES = 9;
  localparam int RESP_BYTES = 5;
  localparam int B_CODE = 0;
  localparam int B_FN = 1;
  localparam int B_TAG_HI = 2;
  localparam int B_TAG_LO = 3;
  localparam int B_PATH0 = 4;
  localparam int B_LUN = 8;
  localparam logic [1:0] UA_NONE = 2'h0;
  localparam logic [1:0] UA_CLEARED_BY_OTHER = 2'h1;
  localparam logic [1:0] UA_POWER_ON_RESET = 2'h2;
endpackage : tmc_pkg

// ===== hdl/tmc_handler.sv
// Task management handler: clear task set, target reset, clear allegiance
`timescale 1ns/1ps
module tmc_handler #(
  parameter int NUM_INIT = 4,
  parameter int NUM_LUN = 8
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_msg_valid, // Message byte strobe
  input wire logic [7:0] i_msg_byte, // Message byte
  input wire logic i_msg_last, // Last byte of message
  input wire logic [$clog2(NUM_INIT)-1:0] i_msg_init, // Sending initiator
  input wire logic [NUM_LUN-1:0] i_lun_attached, // Supported and attached units
  input wire logic [NUM_LUN*NUM_INIT-1:0] i_allegiance, // Allegiance per unit and initiator
  input wire logic [NUM_LUN*NUM_INIT-1:0] i_task_present, // Live tasks per unit and initiator
  input wire logic i_data_req_busy, // Outstanding requested data still arriving
  input wire logic i_status_busy, // Completed-task status still queued
  input wire logic i_resp_ready, // Response path accepts a byte
  output logic o_busy, // Handler busy
  output logic o_flush_data, // Discard incoming requested data
  output logic o_abort_valid, // Abort strobe
  output logic o_abort_all, // Abort covers every unit
  output logic [7:0] o_abort_lun, // Unit to abort and clear
  output logic o_clear_pending, // Discard pending status and data of unit
  output logic o_status_block, // No status may leave for aborted tasks
  output logic o_target_reset, // Reservations, allegiances, modes to power-on
  output logic o_alg_clear, // Clear one allegiance
  output logic [$clog2(NUM_INIT)-1:0] o_alg_init, // Initiator of cleared allegiance
  output logic [NUM_INIT-1:0] o_ua_set, // Unit attention set strobe per initiator
  output logic [1:0] o_ua_kind, // Unit attention sense kind
  output logic o_resp_valid, // Response byte strobe
  output logic [7:0] o_resp_byte, // Response byte
  output logic o_resp_last, // Last response byte
  output logic [31:0] o_resp_path // Reply path identifier
);
  localparam int IW = $clog2(NUM_INIT);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_RECV = 7'b0000010, ST_DRAIN = 7'b0000100,
    ST_ABORT = 7'b0001000, ST_STAT = 7'b0010000, ST_RESP = 7'b0100000,
    ST_SKIP = 7'b1000000
  } tmc_state_t;

  function automatic logic [NUM_INIT-1:0] lun_row(input logic [NUM_LUN*NUM_INIT-1:0] v, input logic [7:0] l);
    lun_row = v[l[$clog2(NUM_LUN)-1:0]*NUM_INIT +: NUM_INIT];
  endfunction : lun_row

  tmc_state_t st_ff, nxt_st;
  logic [3:0] idx_ff, nxt_idx;
  logic [7:0] fn_ff, nxt_fn;
  logic [15:0] tag_ff, nxt_tag;
  logic [31:0] path_ff, nxt_path;
  logic [7:0] lun_ff, nxt_lun;
  logic [IW-1:0] init_ff, nxt_init;
  logic [7:0] rc_ff, nxt_rc;
  logic [2:0] ridx_ff, nxt_ridx;
  logic flush_ff, nxt_flush, abort_ff, nxt_abort, all_ff, nxt_all, clr_ff, nxt_clr;
  logic blk_ff, nxt_blk, trst_ff, nxt_trst, alg_ff, nxt_alg;
  logic [NUM_INIT-1:0] ua_ff, nxt_ua;
  logic [1:0] uak_ff, nxt_uak;
  logic rv_ff, nxt_rv, rl_ff, nxt_rl, busy_ff, nxt_busy;
  logic [7:0] rb_ff, nxt_rb;
  logic lun_ok;
  logic [NUM_INIT-1:0] victims, alg_row;

  always_comb
  begin
    lun_ok = (lun_ff < 8'(NUM_LUN)) && i_lun_attached[lun_ff[$clog2(NUM_LUN)-1:0]];
    victims = lun_row(i_task_present, lun_ff);
    alg_row = lun_row(i_allegiance, lun_ff);
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_fn = fn_ff;
    nxt_tag = tag_ff;
    nxt_path = path_ff;
    nxt_lun = lun_ff;
    nxt_init = init_ff;
    nxt_rc = rc_ff;
    nxt_ridx = ridx_ff;
    nxt_flush = 1'b0;
    nxt_abort = 1'b0;
    nxt_all = all_ff;
    nxt_clr = 1'b0;
    nxt_blk = blk_ff;
    nxt_trst = 1'b0;
    nxt_alg = 1'b0;
    nxt_ua = '0;
    nxt_uak = uak_ff;
    nxt_rv = 1'b0;
    nxt_rl = 1'b0;
    nxt_rb = rb_ff;
    case (st_ff)
      ST_IDLE, ST_RECV, ST_SKIP:
      begin
        if (i_msg_valid)
        begin
          if (st_ff == ST_IDLE)
          begin
            nxt_idx = 4'h1;
            nxt_init = i_msg_init;
            nxt_lun = 8'h00;
            nxt_st = (i_msg_byte == tmc_pkg::MSG_CODE) ? ST_RECV : ST_SKIP;
          end
          else
          begin
            nxt_idx = (idx_ff == 4'hF) ? idx_ff : idx_ff + 4'h1; // Saturate: long messages never wrap onto byte 1
            if (st_ff == ST_RECV)
            begin
              case (int'(idx_ff))
                tmc_pkg::B_FN:
                begin
                  nxt_fn = i_msg_byte;
                  // Other function codes belong to other handlers
                  if (i_msg_byte != tmc_pkg::FN_CLEAR_TASK_SET && i_msg_byte != tmc_pkg::FN_TARGET_RESET &&
                      i_msg_byte != tmc_pkg::FN_CLEAR_ALLEGIANCE)
                  begin
                    nxt_st = ST_SKIP;
                  end
                end
                tmc_pkg::B_TAG_HI: nxt_tag = {i_msg_byte, tag_ff[7:0]};
                tmc_pkg::B_TAG_LO: nxt_tag = {tag_ff[15:8], i_msg_byte};
                tmc_pkg::B_PATH0, tmc_pkg::B_PATH0 + 1, tmc_pkg::B_PATH0 + 2, tmc_pkg::B_PATH0 + 3:
                  nxt_path = {path_ff[23:0], i_msg_byte};
                tmc_pkg::B_LUN: nxt_lun = i_msg_byte;
                default: nxt_lun = lun_ff;
              endcase
            end
          end
          if (i_msg_last)
          begin
            // Short messages are dropped; target reset needs only 8 bytes
            if (st_ff == ST_RECV && ((fn_ff == tmc_pkg::FN_TARGET_RESET && idx_ff >= 4'(tmc_pkg::B_LUN - 1)) ||
                idx_ff >= 4'(tmc_pkg::B_LUN)))
            begin
              nxt_st = ST_DRAIN;
            end
            else
            begin
              nxt_st = ST_IDLE;
            end
          end
        end
      end
      ST_DRAIN:
      begin
        nxt_flush = 1'b1;
        if (fn_ff == tmc_pkg::FN_CLEAR_ALLEGIANCE)
        begin
          // Allegiance clear touches only this initiator on this unit
          nxt_flush = 1'b0;
          if (!lun_ok)
          begin
            nxt_rc = tmc_pkg::RC_INVALID_FIELD;
          end
          else if (alg_row[init_ff])
          begin
            nxt_alg = 1'b1;
            nxt_rc = tmc_pkg::RC_SUCCESS;
          end
          else
          begin
            nxt_rc = tmc_pkg::RC_NO_ALLEGIANCE;
          end
          nxt_st = ST_RESP;
          nxt_ridx = 3'h0;
        end
        else if (fn_ff == tmc_pkg::FN_CLEAR_TASK_SET && !lun_ok)
        begin
          nxt_flush = 1'b0;
          nxt_rc = tmc_pkg::RC_INVALID_FIELD;
          nxt_st = ST_RESP;
          nxt_ridx = 3'h0;
        end
        else if (!i_data_req_busy)
        begin
          nxt_st = ST_ABORT;
        end
      end
      ST_ABORT:
      begin
        nxt_abort = 1'b1;
        nxt_all = (fn_ff == tmc_pkg::FN_TARGET_RESET);
        if (fn_ff == tmc_pkg::FN_TARGET_RESET)
        begin
          // Initiator tables and event reporting are outside this strobe
          nxt_trst = 1'b1;
          nxt_ua = '1;
          nxt_uak = tmc_pkg::UA_POWER_ON_RESET;
        end
        else
        begin
          nxt_clr = 1'b1;
          nxt_ua = victims;
          nxt_uak = tmc_pkg::UA_CLEARED_BY_OTHER;
        end
        nxt_rc = tmc_pkg::RC_SUCCESS;
        nxt_st = ST_STAT;
      end
      ST_STAT:
      begin
        // Completed status must drain before the answer
        if (!i_status_busy)
        begin
          nxt_blk = 1'b1;
          nxt_st = ST_RESP;
          nxt_ridx = 3'h0;
        end
      end
      ST_RESP:
      begin
        if (!rv_ff || i_resp_ready)
        begin
          nxt_rv = 1'b1;
          nxt_ridx = ridx_ff + 3'h1;
          nxt_rl = (ridx_ff == 3'(tmc_pkg::RESP_BYTES - 1));
          case (ridx_ff)
            3'h0: nxt_rb = tmc_pkg::MSG_CODE;
            3'h1: nxt_rb = tmc_pkg::FN_RESPONSE;
            3'h2: nxt_rb = tag_ff[15:8];
            3'h3: nxt_rb = tag_ff[7:0];
            3'h4: nxt_rb = rc_ff;
            default: nxt_rv = 1'b0;
          endcase
          if (ridx_ff == 3'(tmc_pkg::RESP_BYTES))
          begin
            nxt_blk = 1'b0;
            nxt_st = ST_IDLE;
          end
        end
        else
        begin
          nxt_rv = rv_ff;
          nxt_rl = rl_ff;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    nxt_busy = (nxt_st != ST_IDLE);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      st_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      fn_ff <= 8'h00;
      tag_ff <= 16'h0000;
      path_ff <= 32'h00000000;
      lun_ff <= 8'h00;
      init_ff <= '0;
      rc_ff <= 8'h00;
      ridx_ff <= 3'h0;
      flush_ff <= 1'b0;
      abort_ff <= 1'b0;
      all_ff <= 1'b0;
      clr_ff <= 1'b0;
      blk_ff <= 1'b0;
      trst_ff <= 1'b0;
      alg_ff <= 1'b0;
      ua_ff <= '0;
      uak_ff <= tmc_pkg::UA_NONE;
      rv_ff <= 1'b0;
      rl_ff <= 1'b0;
      rb_ff <= 8'h00;
      busy_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      fn_ff <= nxt_fn;
      tag_ff <= nxt_tag;
      path_ff <= nxt_path;
      lun_ff <= nxt_lun;
      init_ff <= nxt_init;
      rc_ff <= nxt_rc;
      ridx_ff <= nxt_ridx;
      flush_ff <= nxt_flush;
      abort_ff <= nxt_abort;
      all_ff <= nxt_all;
      clr_ff <= nxt_clr;
      blk_ff <= nxt_blk;
      trst_ff <= nxt_trst;
      alg_ff <= nxt_alg;
      ua_ff <= nxt_ua;
      uak_ff <= nxt_uak;
      rv_ff <= nxt_rv;
      rl_ff <= nxt_rl;
      rb_ff <= nxt_rb;
      busy_ff <= nxt_busy;
    end
  end

  assign o_busy = busy_ff;
  assign o_flush_data = flush_ff;
  assign o_abort_valid = abort_ff;
  assign o_abort_all = all_ff;
  assign o_abort_lun = lun_ff;
  assign o_clear_pending = clr_ff;
  assign o_status_block = blk_ff;
  assign o_target_reset = trst_ff;
  assign o_alg_clear = alg_ff;
  assign o_alg_init = init_ff;
  assign o_ua_set = ua_ff;
  assign o_ua_kind = uak_ff;
  assign o_resp_valid = rv_ff;
  assign o_resp_byte = rb_ff;
  assign o_resp_last = rl_ff;
  assign o_resp_path = path_ff;
endmodule : tmc_handler

// ===== sim/tmc_initiator_model.sv
// Initiator model: sends link messages and takes response bytes
`timescale 1ns/1ps
module tmc_initiator_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_slow, // Accept every other cycle
  input wire logic i_resp_valid, // Response byte strobe
  input wire logic [7:0] i_resp_byte, // Response byte
  output logic o_msg_valid, // Message byte strobe
  output logic [7:0] o_msg_byte, // Message byte
  output logic o_msg_last, // Final message byte
  output logic [1:0] o_msg_init, // Sending initiator
  output logic o_resp_ready // Response byte taken
);
  logic [7:0] rsp[$];
  logic tgl = 1'b0;
  initial
  begin
    o_msg_valid = 1'b0;
    o_msg_byte = 8'h00;
    o_msg_last = 1'b0;
    o_msg_init = 2'h0;
  end
  assign o_resp_ready = !i_slow || tgl;
  always @(posedge i_core_clk)
  begin
    tgl <= ~tgl;
    if (i_resp_valid && o_resp_ready) rsp.push_back(i_resp_byte);
  end
  // Whole message per call, one byte per clock
  task automatic send(input logic [7:0] m[], input logic [1:0] ini);
    for (int k = 0; k < m.size(); k++)
    begin
      o_msg_valid <= 1'b1;
      o_msg_byte <= m[k];
      o_msg_last <= (k == m.size() - 1);
      o_msg_init <= ini;
      @(posedge i_core_clk);
    end
    o_msg_valid <= 1'b0;
    o_msg_last <= 1'b0;
    o_msg_byte <= ~m[m.size() - 1];
  endtask : send
endmodule : tmc_initiator_model

// ===== sim/tmc_handler_properties.sv
// Checker: response framing and strobe relations of the handler
`timescale 1ns/1ps
module tmc_handler_properties #(
  parameter int NUM_INIT = 4
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_resp_ready, // Response accepted
  input wire logic o_flush_data, // Draining data
  input wire logic o_abort_valid, // Abort strobe
  input wire logic o_abort_all, // Abort every unit
  input wire logic o_clear_pending, // Pending discard
  input wire logic o_status_block, // Status blocked
  input wire logic o_target_reset, // Power-on modes
  input wire logic o_alg_clear, // Allegiance clear
  input wire logic [NUM_INIT-1:0] o_ua_set, // Unit attention
  input wire logic [1:0] o_ua_kind, // Attention kind
  input wire logic o_resp_valid, // Response strobe
  input wire logic [7:0] o_resp_byte, // Response byte
  input wire logic o_resp_last // Last response byte
);
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic abt_ff, nxt_abt;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  always_comb
  begin
    nxt_idx = idx_ff;
    nxt_abt = abt_ff;
    if (o_resp_valid && i_resp_ready) nxt_idx = o_resp_last ? 3'h0 : idx_ff + 3'h1;
    if (o_abort_valid) nxt_abt = 1'b1;
    // Answer fully taken closes the abort episode
    if (o_resp_valid && i_resp_ready && o_resp_last) nxt_abt = 1'b0;
    if (i_rst) nxt_idx = 3'h0;
    if (i_rst) nxt_abt = 1'b0;
  end
  always_ff @(posedge i_core_clk)
  begin
    idx_ff <= nxt_idx;
    abt_ff <= nxt_abt;
  end
  a_resp_hold: assert property (
    o_resp_valid && !i_resp_ready |=> o_resp_valid && $stable(o_resp_byte) && $stable(o_resp_last))
    else $error("response byte changed before accept");
  a_resp_code: assert property (
    o_resp_valid && idx_ff == 3'h0 |-> o_resp_byte == tmc_pkg::MSG_CODE) else $error("bad message code");
  a_resp_fn: assert property (
    o_resp_valid && idx_ff == 3'h1 |-> o_resp_byte == tmc_pkg::FN_RESPONSE) else $error("bad function");
  a_resp_len: assert property (
    o_resp_valid |-> o_resp_last == (idx_ff == 3'h4)) else $error("response length wrong");
  a_rc_legal: assert property (
    o_resp_valid && idx_ff == 3'h4 |-> o_resp_byte inside {8'h00, 8'h20, 8'hFF}) else $error("bad return code");
  a_block_resp: assert property (
    o_resp_valid && abt_ff |-> o_status_block) else $error("status not blocked");
  a_block_none: assert property (
    o_resp_valid && !abt_ff |-> !o_status_block) else $error("status blocked without abort");
  a_reset_ua: assert property (
    o_abort_valid && o_abort_all |-> o_target_reset && o_ua_set == '1 && o_ua_kind == tmc_pkg::UA_POWER_ON_RESET)
    else $error("reset side effects missing");
  a_pending_unit: assert property (
    o_clear_pending |-> o_abort_valid && !o_abort_all) else $error("pending clear without unit abort");
  a_alg_alone: assert property (
    o_alg_clear |-> !o_abort_valid && o_ua_set == '0) else $error("allegiance clear disturbed others");
  a_flush_first: assert property (
    $rose(o_abort_valid) |-> $past(o_flush_data) || $past(o_flush_data, 2)) else $error("abort before flush");
endmodule : tmc_handler_properties
bind tmc_handler tmc_handler_properties #(.NUM_INIT(NUM_INIT)) u_props (.*);

// ===== sim/testbench.sv
// Testbench: drives link messages into the handler and judges responses
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic mv, ml, rv, rl, rr, busy, fd, av, aa, cpo, sb, tro, aco;
  logic [7:0] mb, al, rb;
  logic [1:0] mi, aio, uko;
  logic [3:0] uso;
  logic [31:0] rpo;
  logic [31:0] alg = '0;
  logic [31:0] tp = '0;
  int busy_until = 0;
  int stat_until = 0;
  logic clr = 1'b0;
  logic [7:0] att = 8'hDF;
  int cyc = 0;
  int err_total = 0;
  int compares = 0;
  logic ab, ab_all, cp, tr, ac, fl, bad;
  logic [7:0] ab_lun;
  logic [3:0] ua;
  logic [1:0] uk, ai;
  logic [31:0] rp;
  initial forever #4 clk = ~clk;
  // Unit 5 left unattached
  tmc_handler #(.NUM_INIT(4), .NUM_LUN(8)) dut (.i_core_clk(clk), .i_rst(rst), .i_msg_valid(mv),
    .i_msg_byte(mb), .i_msg_last(ml), .i_msg_init(mi), .i_lun_attached(att), .i_allegiance(alg),
    .i_task_present(tp), .i_data_req_busy(cyc < busy_until), .i_status_busy(cyc < stat_until), .i_resp_ready(rr),
    .o_busy(busy), .o_flush_data(fd), .o_abort_valid(av), .o_abort_all(aa), .o_abort_lun(al),
    .o_clear_pending(cpo), .o_status_block(sb), .o_target_reset(tro), .o_alg_clear(aco), .o_alg_init(aio),
    .o_ua_set(uso), .o_ua_kind(uko), .o_resp_valid(rv), .o_resp_byte(rb), .o_resp_last(rl), .o_resp_path(rpo));
  tmc_initiator_model u_init (.i_core_clk(clk), .i_slow(slow), .i_resp_valid(rv), .i_resp_byte(rb),
    .o_msg_valid(mv), .o_msg_byte(mb), .o_msg_last(ml), .o_msg_init(mi), .o_resp_ready(rr));
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (clr)
    begin
      {ab, cp, tr, ac, fl, bad, ua} <= '0;
    end
    else
    begin
      // Abort while data still arrives, or answer while status still queued
      if ((av && cyc < busy_until) || (rv && cyc < stat_until)) bad <= 1'b1;
      ab <= ab | av;
      if (av) ab_all <= aa;
      if (av) ab_lun <= al;
      ua <= ua | uso;
      if (|uso) uk <= uko;
      cp <= cp | cpo;
      tr <= tr | tro;
      ac <= ac | aco;
      if (aco) ai <= aio;
      fl <= fl | fd;
      if (rv) rp <= rpo;
    end
    if (cyc == 3000) summarize(1'b1);
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic summarize(input bit late);
    err_total += late;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Sends one message; data busy stays up for h cycles first, status busy for h + h/2
  task automatic run(input logic [7:0] fn, input logic [7:0] lun, input logic [1:0] ini, input int n,
                     input logic [7:0] rc, input bit ans, input int h);
    logic [7:0] m[];
    logic [7:0] exp [5];
    m = '{8'h83, fn, 8'hA5, fn, 8'h12, 8'h34, lun, fn, lun};
    m = new[n](m);
    exp = '{8'h83, 8'h03, 8'hA5, fn, rc};
    @(posedge clk);
    clr <= 1'b1;
    busy_until <= cyc + h;
    stat_until <= cyc + h + h / 2;
    u_init.rsp.delete();
    @(posedge clk);
    clr <= 1'b0;
    u_init.send(m, ini);
    for (int k = 0; k < 60 && u_init.rsp.size() < 5; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("resp count", ans ? 5 : 0, u_init.rsp.size());
    for (int k = 0; k < u_init.rsp.size() && k < 5; k++) chk("resp byte", exp[k], u_init.rsp[k]);
    if (ans) chk("path", {8'h12, 8'h34, lun, fn}, rp);
    chk("idle", 1'b0, busy);
    chk("early answer", 1'b0, bad);
  endtask : run
  task automatic t_clear_set();
    tp <= 32'h0000_2900;
    slow <= 1'b1;
    run(8'h32, 8'h02, 2'h1, 9, 8'h00, 1'b1, 16);
    chk("abort", 1'b1, ab);
    chk("abort all", 1'b0, ab_all);
    chk("abort unit", 8'h02, ab_lun);
    chk("pending", 1'b1, cp);
    chk("flush", 1'b1, fl);
    chk("ua mask", 4'h9, ua);
    chk("ua kind", tmc_pkg::UA_CLEARED_BY_OTHER, uk);
    run(8'h32, 8'h05, 2'h1, 9, 8'hFF, 1'b1, 0);
    chk("abort bad unit", 1'b0, ab);
  endtask : t_clear_set
  task automatic t_reset();
    slow <= 1'b0;
    run(8'h33, 8'h07, 2'h2, 8, 8'h00, 1'b1, 14);
    chk("abort all", 1'b1, ab_all);
    chk("modes", 1'b1, tr);
    chk("ua mask", 4'hF, ua);
    chk("ua kind", tmc_pkg::UA_POWER_ON_RESET, uk);
  endtask : t_reset
  task automatic t_allegiance();
    alg <= 32'h0000_6000;
    run(8'h34, 8'h03, 2'h1, 9, 8'h00, 1'b1, 0);
    chk("alg clear", 1'b1, ac);
    chk("alg init", 2'h1, ai);
    chk("no abort", 1'b0, ab);
    run(8'h34, 8'h04, 2'h1, 9, 8'h20, 1'b1, 0);
    chk("alg none", 1'b0, ac);
    run(8'h34, 8'h09, 2'h0, 9, 8'hFF, 1'b1, 0);
  endtask : t_allegiance
  task automatic t_ignored();
    run(8'h35, 8'h02, 2'h0, 9, 8'h00, 1'b0, 0);
    chk("no abort other fn", 1'b0, ab);
    run(8'h32, 8'h02, 2'h0, 7, 8'h00, 1'b0, 0);
    chk("no abort", 1'b0, ab);
  endtask : t_ignored
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_clear_set();
    t_reset();
    t_allegiance();
    t_ignored();
    summarize(1'b0);
  end
endmodule : testbench
